//--- verilog/flash_flag_status_and_block_protect.sv
// Purpose: flag status byte, status byte and block protect of a serial flash
// Assumes: SPI mode 0 sampled on clk; cs_n and sdi synchronous to clk
// Notes:   command byte then one data byte; opcodes are parameters
`timescale 1ns/100ps
module flash_flag_status_and_block_protect
#(
  parameter logic [7:0] OP_RD_FLAG  = 8'h70,
  parameter logic [7:0] OP_CLR_FLAG = 8'h50,
  parameter logic [7:0] OP_RD_STS   = 8'h05,
  parameter logic [7:0] OP_WR_STS   = 8'h01
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   cs_n,
  input  wire logic                   sck,
  input  wire logic                   sdi,
  output logic                        sdo,
  output logic                        sdo_oe_n,
  input  wire logic                   busy,
  input  wire logic                   erase_suspend,
  input  wire logic                   program_suspend,
  input  wire logic                   vpp_disabled,
  input  wire logic                   write_latch_flag,
  input  wire logic                   erase_fail_evt,
  input  wire logic                   program_fail_evt,
  input  wire logic [flash_status_pkg::SECTOR_BITS-1:0] op_sector,
  input  wire logic                   op_req,
  output logic                        op_reject,
  output logic [7:0]                  flag_byte,
  output logic [7:0]                  status_byte
);
  import flash_status_pkg::*;
  shift_e            st_r, st_nxt;
  logic [7:0]        sr_r, sr_nxt, tx_r, tx_nxt;
  logic [2:0]        bit_r, bit_nxt;
  logic [7:0]        op_r, op_nxt;
  logic              sck_r;
  logic [4:0]        code_r, code_nxt;
  logic              lock_r, lock_nxt;
  logic              ef_r, ef_nxt, pf_r, pf_nxt, xf_r, xf_nxt;
  logic              rej_r, rej_nxt;
  logic              rise, fall, byte_done, locked, clr;
  logic [7:0]        rx_byte;

  protect_decode #(.SB(SECTOR_BITS)) protect_decode_inst (
    .code   (code_r),
    .sector (op_sector),
    .locked (locked)
  );

  assign rise      = sck && !sck_r && !cs_n;
  assign fall      = !sck && sck_r && !cs_n;
  assign rx_byte   = {sr_r[6:0], sdi};
  assign byte_done = rise && (bit_r == 3'd7);
  assign clr       = byte_done && st_r == SH_CMD && rx_byte == OP_CLR_FLAG;

  always_comb begin
    flag_byte                = BYTE_ZERO;
    flag_byte[FLG_READY]     = !busy;
    flag_byte[FLG_ERS_SUSP]  = erase_suspend;
    flag_byte[FLG_PGM_SUSP]  = program_suspend;
    flag_byte[FLG_ERS_FAIL]  = ef_r;
    flag_byte[FLG_PGM_FAIL]  = pf_r;
    flag_byte[FLG_PROT_FAIL] = xf_r;
    flag_byte[FLG_VPP_DIS]   = vpp_disabled;
    status_byte                                    = BYTE_ZERO;
    status_byte[STS_LOCK]                          = lock_r;
    status_byte[STS_CODE_LSB+CODE_BITS-1:STS_CODE_LSB] = code_r;
    status_byte[STS_WEL]                           = write_latch_flag;
    status_byte[STS_WIP]                           = busy;
  end

  always_comb begin
    st_nxt   = st_r;
    sr_nxt   = sr_r;
    tx_nxt   = tx_r;
    bit_nxt  = bit_r;
    op_nxt   = op_r;
    code_nxt = code_r;
    lock_nxt = lock_r;
    if (cs_n) begin
      st_nxt  = SH_IDLE;
      bit_nxt = 3'd0;
    end else begin
      if (st_r == SH_IDLE) begin
        st_nxt = SH_CMD;
      end
      if (rise) begin
        sr_nxt  = rx_byte;
        bit_nxt = bit_r + 3'd1;
      end
      // first fall after the load keeps bit 7 on the pin
      if (fall && st_r == SH_DATA && bit_r != 3'd0) begin
        tx_nxt = {tx_r[6:0], 1'b0};
      end
      if (byte_done) begin
        unique case (st_r)
          SH_IDLE, SH_CMD: begin
            op_nxt = rx_byte;
            st_nxt = SH_DATA;
            if (rx_byte == OP_RD_FLAG) begin
              tx_nxt = flag_byte;
            end else if (rx_byte == OP_RD_STS) begin
              tx_nxt = status_byte;
            end else begin
              tx_nxt = BYTE_ZERO;
            end
          end
          SH_DATA: begin
            tx_nxt = BYTE_ZERO;
            if (op_r == OP_WR_STS && write_latch_flag && !busy) begin
              lock_nxt = rx_byte[STS_LOCK];
              if (!lock_r) begin
                code_nxt = rx_byte[STS_CODE_LSB+CODE_BITS-1:STS_CODE_LSB];
              end
            end
            op_nxt = BYTE_ZERO;
          end
        endcase
      end
    end
  end

  always_comb begin
    ef_nxt  = ef_r;
    pf_nxt  = pf_r;
    xf_nxt  = xf_r;
    rej_nxt = op_req && locked;
    if (clr) begin
      ef_nxt = 1'b0;
      pf_nxt = 1'b0;
      xf_nxt = 1'b0;
    end
    if (erase_fail_evt) begin
      ef_nxt = 1'b1;
    end
    if (program_fail_evt) begin
      pf_nxt = 1'b1;
    end
    if (rej_nxt) begin
      xf_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r   <= SH_IDLE;
      sr_r   <= BYTE_ZERO;
      tx_r   <= BYTE_ZERO;
      bit_r  <= 3'd0;
      op_r   <= BYTE_ZERO;
      sck_r  <= 1'b0;
      code_r <= PC_RESET;
      lock_r <= 1'b0;
      ef_r   <= 1'b0;
      pf_r   <= 1'b0;
      xf_r   <= 1'b0;
      rej_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      sr_r   <= sr_nxt;
      tx_r   <= tx_nxt;
      bit_r  <= bit_nxt;
      op_r   <= op_nxt;
      sck_r  <= sck;
      code_r <= code_nxt;
      lock_r <= lock_nxt;
      ef_r   <= ef_nxt;
      pf_r   <= pf_nxt;
      xf_r   <= xf_nxt;
      rej_r  <= rej_nxt;
    end
  end

  assign sdo       = tx_r[7];
  assign sdo_oe_n  = !(st_r == SH_DATA && !cs_n);
  assign op_reject = rej_r;

  a_ready_bit: assert property (@(posedge clk) disable iff (sys_rst)
    flag_byte[FLG_READY] == !busy) else $error("ready bit wrong");
  a_susp_bits: assert property (@(posedge clk) disable iff (sys_rst)
    flag_byte[FLG_ERS_SUSP] == erase_suspend && flag_byte[FLG_PGM_SUSP] == program_suspend)
    else $error("suspend bits wrong");
  a_fail_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    erase_fail_evt |=> flag_byte[FLG_ERS_FAIL]) else $error("erase fail lost");
  a_clear_flags: assert property (@(posedge clk) disable iff (sys_rst)
    clr && !erase_fail_evt && !program_fail_evt && !(op_req && locked)
    |=> !flag_byte[FLG_ERS_FAIL] && !flag_byte[FLG_PGM_FAIL] && !flag_byte[FLG_PROT_FAIL])
    else $error("flags not cleared");
  a_lock_code: assert property (@(posedge clk) disable iff (sys_rst)
    lock_r |=> $stable(code_r)) else $error("locked code changed");
  a_code_03: assert property (@(posedge clk) disable iff (sys_rst)
    op_req && code_r == 5'h03 |=> op_reject == ($past(op_sector) >= 11'd2044))
    else $error("code 3 decode");
  a_code_04: assert property (@(posedge clk) disable iff (sys_rst)
    op_req && code_r == 5'h04 |=> op_reject == ($past(op_sector) >= 11'd2040))
    else $error("code 4 decode");
  a_code_05: assert property (@(posedge clk) disable iff (sys_rst)
    op_req && code_r == 5'h05 |=> op_reject == ($past(op_sector) >= 11'd2032))
    else $error("code 5 decode");
  a_code_06: assert property (@(posedge clk) disable iff (sys_rst)
    op_req && code_r == 5'h06 |=> op_reject == ($past(op_sector) >= 11'd2016))
    else $error("code 6 decode");
  a_code_small: assert property (@(posedge clk) disable iff (sys_rst)
    op_req && code_r == 5'h00 |=> !op_reject) else $error("code 0 locks");
  a_status_map: assert property (@(posedge clk) disable iff (sys_rst)
    status_byte[6:2] == code_r && status_byte[0] == busy) else $error("status map");
  a_wel_bit: assert property (@(posedge clk) disable iff (sys_rst)
    status_byte[STS_WEL] == write_latch_flag) else $error("latch bit");
  a_one_byte: assert property (@(posedge clk) disable iff (sys_rst)
    byte_done && st_r == SH_DATA |=> tx_r == BYTE_ZERO) else $error("extra byte");
endmodule

//--- verilog/flash_status_pkg.sv
// Purpose: shared constants for the flash status and block-protect logic
// Assumes: 2048 sectors, top-anchored protect codes decoded in protect_decode
// Notes:   bit positions of flag byte and status byte
package flash_status_pkg;
  localparam int unsigned SECTOR_BITS   = 11;
  localparam int unsigned NUM_SECTORS   = 2048;
  localparam int unsigned CODE_BITS     = 5;
  // flag status byte fields
  localparam int unsigned FLG_READY     = 7;
  localparam int unsigned FLG_ERS_SUSP  = 6;
  localparam int unsigned FLG_ERS_FAIL  = 5;
  localparam int unsigned FLG_PGM_FAIL  = 4;
  localparam int unsigned FLG_VPP_DIS   = 3;
  localparam int unsigned FLG_PGM_SUSP  = 2;
  localparam int unsigned FLG_PROT_FAIL = 1;
  localparam int unsigned FLG_RSVD      = 0;
  // status byte fields
  localparam int unsigned STS_LOCK      = 7;
  localparam int unsigned STS_CODE_LSB  = 2;
  localparam int unsigned STS_WEL       = 1;
  localparam int unsigned STS_WIP       = 0;
  // protect code fields
  localparam int unsigned PC_SIZE3      = 4;
  localparam int unsigned PC_TB         = 3;
  localparam logic [4:0]  PC_RESET      = 5'h00;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_CMD  = 2'b01,
    SH_DATA = 2'b11
  } shift_e;
endpackage

//--- verilog/protect_decode.sv
// Purpose: decide whether a sector is locked by a protect code
// Assumes: top-anchored codes of nonzero size lock; any code with size above 11 locks all sectors; others lock nothing
// Notes:   combinational
`timescale 1ns/100ps
module protect_decode
#(
  parameter int unsigned SB = flash_status_pkg::SECTOR_BITS
) (
  input  wire logic [4:0]    code,
  input  wire logic [SB-1:0] sector,
  output logic               locked
);
  import flash_status_pkg::*;
  logic [SB:0]   count;
  logic [SB:0]   first;
  logic [3:0]    size;
  always_comb begin
    size  = {code[PC_SIZE3], code[2:0]};
    count = '0;
    if (!code[PC_TB] && size != 4'h0) begin
      count = (SB+1)'(1) << (size - 4'h1);
    end
    if (size > 4'hb) begin
      count = (SB+1)'(NUM_SECTORS);
    end
    first  = (SB+1)'(NUM_SECTORS) - count;
    locked = (count != '0) && ({1'b0, sector} >= first);
  end
endmodule

//--- verif/spi_host_model.sv
// Purpose: spi host that drives the flash status block
// Assumes: mode 0, two clk cycles per sck phase
// Notes:   xfer is called by the bench, msb first
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end
  task automatic xfer(input logic [15:0] bits, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdi <= bits[i];
      repeat (2) @(posedge clk);
      sck <= 1'b1;
      rx  = {rx[6:0], sdo};
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    repeat (3) @(posedge clk);
  endtask
endmodule

//--- verif/flash_flag_status_and_block_protect_bench.sv
// Purpose: self-checking bench for flag status and block protect
// Assumes: default opcodes of the design
// Notes:   reference state kept in m_ variables
`timescale 1ns/100ps
module flash_flag_status_and_block_protect_bench;
  import flash_status_pkg::*;
  logic                   clk, sys_rst, cs_n, sck, sdi, sdo, sdo_oe_n, op_req, op_reject;
  logic                   busy, erase_suspend, program_suspend, vpp_disabled, write_latch_flag;
  logic                   erase_fail_evt, program_fail_evt, m_ef, m_pf, m_xf, m_lock;
  logic [SECTOR_BITS-1:0] op_sector;
  logic [4:0]             m_code;
  logic [7:0]             flag_byte, status_byte, rx;
  int                     bad_count, n_checks, seed;
  int                     sect [10] = '{2047, 2043, 2044, 2040, 2039, 2032, 2031, 2016, 2015, 0};
  flash_flag_status_and_block_protect flash_flag_status_and_block_protect_inst (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .busy(busy), .erase_suspend(erase_suspend),
    .program_suspend(program_suspend), .vpp_disabled(vpp_disabled),
    .write_latch_flag(write_latch_flag), .erase_fail_evt(erase_fail_evt),
    .program_fail_evt(program_fail_evt), .op_sector(op_sector), .op_req(op_req),
    .op_reject(op_reject), .flag_byte(flag_byte), .status_byte(status_byte));
  spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  function automatic logic locked(input logic [4:0] c, input int s);
    int sz;
    sz = int'({c[4], c[2:0]});
    if (c[3] || sz == 0) return 1'b0;
    return s >= 2048 - (1 << (sz - 1));
  endfunction
  function automatic logic [7:0] exp_flag();
    return {~busy, erase_suspend, m_ef, m_pf, vpp_disabled, program_suspend, m_xf, 1'b0};
  endfunction
  function automatic logic [7:0] exp_sts();
    return {m_lock, m_code, write_latch_flag, busy};
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_sts(input logic [7:0] d);
    host.xfer({8'h01, d}, 16, rx);
    if (write_latch_flag && !busy) begin
      if (!m_lock) m_code = d[6:2];
      m_lock = d[7];
    end
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    fork
      host.xfer({op, 8'h00}, 16, rx);
      begin
        repeat (40) @(posedge clk);
        #1 chk_bit(sdo_oe_n, 1'b0);
      end
    join
    chk_byte(rx, e);
    chk_bit(sdo_oe_n, 1'b1);
  endtask
  task automatic op_chk(input int s);
    logic e;
    e = locked(m_code, s);
    @(posedge clk) begin
      op_sector <= s[10:0];
      op_req    <= 1'b1;
    end
    @(posedge clk) op_req <= 1'b0;
    #1 chk_bit(op_reject, e);
    if (e) m_xf = 1'b1;
  endtask
  task automatic set_core(input logic [4:0] v);
    @(posedge clk) {busy, erase_suspend, program_suspend, vpp_disabled, write_latch_flag} <= v;
    @(posedge clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude;
  end
  initial begin
    seed = 32'h0218;
    {bad_count, n_checks} = '0;
    {m_ef, m_pf, m_xf, m_lock, m_code} = '0;
    {sys_rst, busy, erase_suspend, program_suspend, vpp_disabled, write_latch_flag} = 6'h20;
    {erase_fail_evt, program_fail_evt, op_req, op_sector} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 chk_byte(flag_byte, 8'h80);
    chk_byte(status_byte, 8'h00);
    wr_sts(8'h14);
    chk_byte(status_byte, exp_sts());
    set_core(5'h01);
    for (int c = 0; c < 7; c++) begin
      wr_sts(8'(c << 2));
      rd(8'h05, exp_sts());
      for (int k = 0; k < 10; k++) op_chk(sect[k]);
    end
    $display("test protect done");
    wr_sts(8'h8c);
    wr_sts(8'h98);
    rd(8'h05, exp_sts());
    wr_sts(8'h00);
    chk_byte(status_byte, exp_sts());
    $display("test lock done");
    @(posedge clk) {erase_fail_evt, program_fail_evt} <= 2'b11;
    @(posedge clk) {erase_fail_evt, program_fail_evt} <= 2'b00;
    {m_ef, m_pf} = 2'b11;
    rd(8'h70, exp_flag());
    host.xfer({8'h50, 8'h00}, 8, rx);
    {m_ef, m_pf, m_xf} = 3'b000;
    chk_byte(flag_byte, exp_flag());
    rd(8'h3c, 8'h00);
    $display("test clear done");
    for (int i = 0; i < 8; i++) begin
      set_core(5'($random(seed)));
      rd(8'h70, exp_flag());
      chk_byte(flag_byte, exp_flag());
      wr_sts(8'($random(seed)));
      chk_byte(status_byte, exp_sts());
    end
    $display("test random done");
    conclude;
  end
endmodule
